// [ppcr_defs.vh]
// Register map, field layout and reset values of the port pin control block.
// Included by the port module; holds definitions only.
`ifndef PPCR_DEFS_VH
`define PPCR_DEFS_VH

`define PPCR_ADDR_W          4
`define PPCR_OFF_DIRECTION   4'h0
`define PPCR_OFF_PIN_STATE   4'h4
`define PPCR_OFF_OUT_LATCH   4'h8
`define PPCR_OFF_SS_MAP      4'hc

`define PPCR_SS_FIELD_W      5
`define PPCR_SS_FIELD_RST    5'h1f
`define PPCR_SS_CODE_GND     5'h1f
`define PPCR_SS_CODE_MAX     5'h19
`define PPCR_REMAP_PINS      26

`endif

// [ppcr_sync.v]
// Two-flop synchroniser bank for the pin inputs.
// Assumes pins are asynchronous to clk.
`timescale 1ns/1ps
module ppcr_sync #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         arst_n,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule // ppcr_sync

// [ppcr_port.v]
// Parallel I/O port with peripheral output sharing and a remappable
// slave-select input, reached over a classic Wishbone slave.
// Assumes pins are external and asynchronous; peripherals run on clk.
//
// Functional notes
// - Direction bit one means input, zero output.
// - Reset sets all direction bits, pins input.
// - Latch register reads latch, writes latch.
// - Pin register reads pins, writes go latch.
// - Muxes pick peripheral or port data/enable.
// - Driving peripheral disables port, pin readable.
// - Enabled idle peripheral lets port drive pin.
// - Port output never loops into peripheral input; masked only while port drives, so it shows for 2 cycles after.
// - Absent bits read zero everywhere.
// - Input-only shared pin stays dedicated port.
// - Select code routes pin n; 11111 grounds.
// - Map bits 15:5 zero, field resets ones.
//
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "ppcr_defs.vh"
module ppcr_port #(
  parameter         NPINS      = 26,
  parameter [25:0]  VALID_MASK = 26'h3ffffff
) (
  input  wire             clk,
  input  wire             arst_n,
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  input  wire             wb_we_i,
  input  wire [3:0]       wb_adr_i,
  input  wire [3:0]       wb_sel_i,
  input  wire [31:0]      wb_dat_i,
  output wire [31:0]      wb_dat_o,
  output wire             wb_ack_o,
  input  wire [NPINS-1:0] pin_i,
  output wire [NPINS-1:0] pin_o,
  output wire [NPINS-1:0] pin_oe,
  input  wire [NPINS-1:0] periph_en,
  input  wire [NPINS-1:0] periph_drive,
  input  wire [NPINS-1:0] periph_out,
  output wire [NPINS-1:0] periph_in,
  output wire             second_serial_slave_select_input
);
  localparam [NPINS-1:0] VMASK  = VALID_MASK[NPINS-1:0];
  localparam [NPINS-1:0] ALL_IN = {NPINS{1'b1}};
  localparam [NPINS-1:0] NONE   = {NPINS{1'b0}};
  localparam integer     PAD_W  = 32 - NPINS;

  reg  [NPINS-1:0] direction_reg_ff;
  reg  [NPINS-1:0] nxt_direction_reg;
  reg  [NPINS-1:0] output_latch_reg_ff;
  reg  [NPINS-1:0] nxt_output_latch_reg;
  reg  [4:0]       select_input_source_field_ff;
  reg  [4:0]       nxt_select_input_source_field;
  reg  [31:0]      rdata_ff;
  reg  [31:0]      nxt_rdata;
  reg              ack_ff;
  reg              nxt_ack;
  reg              ss_sel;
  reg  [NPINS-1:0] mux_pin_o;
  reg  [NPINS-1:0] mux_pin_oe;
  reg  [NPINS-1:0] loop_block;
  wire [NPINS-1:0] pin_sync;
  wire [NPINS-1:0] periph_owns;
  wire [NPINS-1:0] port_drives;
  wire [31:0]      dir_merged;
  wire [31:0]      lat_merged;
  wire             req;
  wire             wr;
  wire             hit_dir;
  wire             hit_pin;
  wire             hit_lat;
  wire             hit_map;

  ppcr_sync #(.W(NPINS)) u_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .async_in (pin_i),
    .sync_out (pin_sync)
  );

  // Merge byte lanes of a write into the current value
  function [31:0] merge;
    input [31:0] cur;
    input [31:0] wd;
    input [3:0]  sel;
    integer i;
    begin
      merge = cur;
      for (i = 0; i < 4; i = i + 1)
        if (sel[i])
          merge[i*8 +: 8] = wd[i*8 +: 8];
    end
  endfunction

  // True when the bus address selects the given register
  function adr_hit;
    input [3:0] adr;
    input [3:0] off;
    begin
      adr_hit = (adr == off);
    end
  endfunction

  // Slave-select source: pin n for codes up to the last remappable pin;
  // the ground code and the unused codes above the last pin read low
  function ss_pick;
    input [4:0]       code;
    input [NPINS-1:0] pins;
    begin
      ss_pick = 1'b0;
      if (code != `PPCR_SS_CODE_GND && code <= `PPCR_SS_CODE_MAX &&
          code < `PPCR_REMAP_PINS && code < NPINS) begin
        ss_pick = pins[code];
      end
    end
  endfunction

  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr  = req & wb_we_i;

  assign hit_dir = adr_hit(wb_adr_i, `PPCR_OFF_DIRECTION);
  assign hit_pin = adr_hit(wb_adr_i, `PPCR_OFF_PIN_STATE);
  assign hit_lat = adr_hit(wb_adr_i, `PPCR_OFF_OUT_LATCH);
  assign hit_map = adr_hit(wb_adr_i, `PPCR_OFF_SS_MAP);

  assign dir_merged = merge({{PAD_W{1'b0}}, direction_reg_ff}, wb_dat_i, wb_sel_i);
  assign lat_merged = merge({{PAD_W{1'b0}}, output_latch_reg_ff}, wb_dat_i, wb_sel_i);

  // Direction stays all inputs until software clears bits
  always @* begin
    nxt_direction_reg = direction_reg_ff;
    if (wr && hit_dir) begin
      nxt_direction_reg = dir_merged[NPINS-1:0];
    end
  end

  // Latch is written through either the latch or the pin-state address
  always @* begin
    nxt_output_latch_reg = output_latch_reg_ff;
    if (wr && (hit_lat || hit_pin)) begin
      nxt_output_latch_reg = lat_merged[NPINS-1:0];
    end
  end

  // Map field lives in the low byte lane only
  always @* begin
    nxt_select_input_source_field = select_input_source_field_ff;
    if (wr && hit_map && wb_sel_i[0]) begin
      nxt_select_input_source_field = wb_dat_i[`PPCR_SS_FIELD_W-1:0];
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      direction_reg_ff <= ALL_IN;
    end else begin
      direction_reg_ff <= nxt_direction_reg;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      output_latch_reg_ff <= NONE;
    end else begin
      output_latch_reg_ff <= nxt_output_latch_reg;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      select_input_source_field_ff <= `PPCR_SS_FIELD_RST;
    end else begin
      select_input_source_field_ff <= nxt_select_input_source_field;
    end
  end

  // Read mux; absent bits and unmapped addresses read zero
  always @* begin
    nxt_rdata = 32'h0000_0000;
    if (hit_dir) begin
      nxt_rdata[NPINS-1:0] = direction_reg_ff & VMASK;
    end else if (hit_pin) begin
      nxt_rdata[NPINS-1:0] = pin_sync & VMASK;
    end else if (hit_lat) begin
      nxt_rdata[NPINS-1:0] = output_latch_reg_ff & VMASK;
    end else if (hit_map) begin
      nxt_rdata[`PPCR_SS_FIELD_W-1:0] = select_input_source_field_ff;
    end
  end

  // One-cycle ack; a held strobe is taken again only after ack falls
  always @* begin
    nxt_ack = req;
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
    end
  end

  // Read data stands only in the ack cycle, zero otherwise
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (req) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // Peripheral owns a pin only while enabled and actively driving; an
  // input-only function never drives, so the pin stays with the port
  assign periph_owns = periph_en & periph_drive & VMASK;
  assign port_drives = ~direction_reg_ff & ~periph_owns & VMASK;

  // Output multiplexers, chosen bit by bit
  always @* begin
    mux_pin_o  = (periph_owns & periph_out) | (~periph_owns & output_latch_reg_ff);
    mux_pin_oe = periph_owns | port_drives;
  end

  assign pin_o  = mux_pin_o & VMASK;
  assign pin_oe = mux_pin_oe & VMASK;

  // Peripheral sees the pin only; port output is masked off while port drives
  always @* begin
    loop_block = port_drives;
  end

  assign periph_in = pin_sync & VMASK & ~loop_block;

  always @* begin
    ss_sel = ss_pick(select_input_source_field_ff, periph_in);
  end

  assign second_serial_slave_select_input = ss_sel;
endmodule // ppcr_port

// [ppcr_pin_model.sv]
// Pin pads: the port drives where enabled, else the outside level.
// Assumes one fixed outside level per pin and no contention.
`timescale 1ns/1ps
module ppcr_pin_model (
  input  wire [25:0] pin_o,
  input  wire [25:0] pin_oe,
  input  wire [25:0] ext_val,
  output wire [25:0] pin_i
);
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_val);
endmodule // ppcr_pin_model

// [ppcr_props.sv]
// Checker on the port block's bus and pin ports; one clock.
// Assumes it is bound into the port module and sees only its ports.
`timescale 1ns/1ps
module ppcr_props #(
  parameter [25:0] VALID_MASK = 26'h3ffffff
) (
  input wire        clk,
  input wire        arst_n,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire [31:0] wb_dat_o,
  input wire [25:0] pin_o,
  input wire [25:0] pin_oe,
  input wire [25:0] periph_en,
  input wire [25:0] periph_drive,
  input wire [25:0] periph_out,
  input wire [25:0] periph_in
);
  wire [25:0] own = periph_en & periph_drive & VALID_MASK;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  chk_ack_due: assert property (s_req |=> wb_ack_o) else $error("ack late");
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  chk_ack_cause: assert property (!wb_stb_i |=> !wb_ack_o) else $error("stray ack");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 0) else $error("stray data");
  chk_periph_oe: assert property ((own & ~pin_oe) == 0) else $error("oe");
  chk_periph_dat: assert property (((pin_o ^ periph_out) & own) == 0) else $error("out");
  chk_no_loop: assert property ((periph_in & pin_oe & ~own) == 0) else $error("loop");
  chk_absent_off: assert property ((pin_oe & ~VALID_MASK) == 0) else $error("absent");
  chk_absent_dat: assert property ((pin_o & ~VALID_MASK) == 0) else $error("absent data");
endmodule // ppcr_props
bind ppcr_port ppcr_props #(.VALID_MASK(VALID_MASK)) u_props (
  .clk          (clk),
  .arst_n       (arst_n),
  .wb_cyc_i     (wb_cyc_i),
  .wb_stb_i     (wb_stb_i),
  .wb_ack_o     (wb_ack_o),
  .wb_dat_o     (wb_dat_o),
  .pin_o        (pin_o),
  .pin_oe       (pin_oe),
  .periph_en    (periph_en),
  .periph_drive (periph_drive),
  .periph_out   (periph_out),
  .periph_in    (periph_in)
);

// [testbench.sv]
// Bench: register traffic over Wishbone, then pin sharing scenarios.
// Assumes the pin model drives outside levels where the port does not.
`timescale 1ns/1ps
module testbench;
  localparam [25:0] VM = 26'h1ffffff, EXT = 26'h0aaaaaa;
  logic clk = 0, arst_n = 0, cyc = 0, stb = 0, we = 0, ack, ss;
  logic [3:0] adr = 0;
  logic [31:0] dat = 0, q;
  logic [25:0] p_o, p_oe, p_i, en = 0, drv = 0, p_in, pout = 0;
  int n_fail = 0, n_checks = 0, cnt = 0;
  // Rows: we and address, then write data or expected read data
  logic [36:0] tab [10] = '{{5'h18, 32'hffffffff}, {5'h08, 32'h1ffffff},
    {5'h14, 32'h155}, {5'h08, 32'h155}, {5'h04, 32'haaaaaa}, {5'h00, 32'h1ffffff},
    {5'h0c, 32'h1f}, {5'h1c, 32'hffffffe3}, {5'h0c, 32'h3}, {5'h06, 32'h0}};
  ppcr_port #(.VALID_MASK(VM)) u_dut (.clk(clk), .arst_n(arst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack), .pin_i(p_i), .pin_o(p_o), .pin_oe(p_oe),
    .periph_en(en), .periph_drive(drv), .periph_out(pout), .periph_in(p_in),
    .second_serial_slave_select_input(ss));
  ppcr_pin_model u_pins (.pin_o(p_o), .pin_oe(p_oe), .ext_val(EXT), .pin_i(p_i));
  task automatic chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    {cyc, stb} <= 2'b00;
    if (!w) chk(q, d);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cnt++;
    if (cnt == 3000) begin
      n_fail++;
      close_out;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1;
    foreach (tab[i]) xfer(tab[i][36], tab[i][35:32], tab[i][31:0]);
    for (int k = 0; k < 32; k++) begin
      xfer(1, 4'hc, k);
      chk(ss, k < 26 ? EXT[k] : 0);
    end
    xfer(1, 4'h0, 32'h1ffff00);
    chk(p_oe, 26'hff);
    xfer(0, 4'h4, 32'haaaa55);
    en <= 26'h3;
    drv <= 26'h1;
    pout <= 26'h2;
    repeat (3) @(posedge clk);
    xfer(0, 4'h4, 32'haaaa54);
    chk(p_oe[1:0], 2'b11);
    chk(p_o, 26'h154);
    chk(p_in[7:1], 0);
    arst_n <= 0;
    @(posedge clk);
    arst_n <= 1;
    chk(p_oe, 26'h1);
    xfer(0, 4'h0, 32'h1ffffff);
    close_out;
  end
endmodule // testbench
